// file: rtl/pmfcp_ctrl.v
// Programmer-side controller driving the flash command port pins
// Behaviour
// - First write byte picks read, program, erase or status; erase and status repeat it.
// - Program is one command write plus 128 data writes, 129 in all.
// - Page bytes are sent back to back; device programs the page at once.
// - Short pages are padded by the user with 0xff bytes to full 128.
// - Page address is set at the second write and held for the rest.
// - No command is written while program is still running inside; after a poll timeout the next command is written unchecked.
// - Each page is programmed once between erases; the user must keep this.
// - Completion is read on the poll line; a status read then confirms it.
// - Polling starts at least 1 ms after the last page byte.
// - Status read follows program or erase without dropping power.
`timescale 1ns/1ns
`default_nettype none
`include "pmfcp_defs.vh"
module pmfcp_ctrl #(
    parameter AW = 18,
    parameter PAGE_BYTES = `PMFCP_PAGE_BYTES,
    parameter TNXT_CYC = `PMFCP_TNXT_CYC,
    parameter TACC_CYC = `PMFCP_TACC_CYC,
    parameter TSTS_CYC = `PMFCP_TSTS_CYC,
    parameter TINIT_CYC = `PMFCP_TINIT_CYC,
    parameter POLL_LIMIT = `PMFCP_POLL_LIMIT
) (
    input wire sys_clk,
    input wire rst,
    input wire cmd_valid,
    input wire [1:0] cmd_op,
    input wire [AW-1:0] cmd_addr,
    output reg cmd_ready,
    input wire pg_valid,
    input wire [7:0] pg_data,
    output reg pg_ready,
    output reg rsp_valid,
    output reg [7:0] rsp_data,
    output reg rsp_timeout,
    output reg busy,
    output reg ce_n,
    output reg oe_n,
    output reg we_n,
    output reg fwe,
    output reg [AW-1:0] addr,
    output reg [7:0] dq_out,
    output reg dq_oe,
    input wire [7:0] dq_in
);
    localparam [3:0] S_INIT = 4'h0;
    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_WLOW = 4'h2;
    localparam [3:0] S_WHOLD = 4'h3;
    localparam [3:0] S_WGAP = 4'h4;
    localparam [3:0] S_WNEED = 4'h5;
    localparam [3:0] S_PWAIT = 4'h6;
    localparam [3:0] S_RACC = 4'h7;
    localparam [3:0] S_RDF = 4'h8;

    reg [3:0] state_r;
    reg [1:0] op_r;
    reg [7:0] wr_idx_r;
    reg [7:0] rdata_r;
    reg polling_r;
    reg [31:0] poll_cnt_r;
    reg tmr_load_r;
    reg [31:0] tmr_val_r;
    wire tmr_done;

    // Command byte for each user operation
    function [7:0] pmfcp_cmd_byte;
        input [1:0] op;
        begin
            case (op)
                `PMFCP_OP_READ: pmfcp_cmd_byte = `PMFCP_CMD_READ;
                `PMFCP_OP_PROG: pmfcp_cmd_byte = `PMFCP_CMD_PROG;
                `PMFCP_OP_ERASE: pmfcp_cmd_byte = `PMFCP_CMD_ERASE;
                default: pmfcp_cmd_byte = `PMFCP_CMD_STATUS;
            endcase
        end
    endfunction

    // Shared phase timer
    pmfcp_timer #(
        .W(32)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(tmr_load_r),
        .load_val(tmr_val_r),
        .expired(tmr_done)
    );

    // Arm the phase timer
    task arm;
        input [31:0] cyc;
        begin
            tmr_load_r <= 1'b1;
            tmr_val_r <= cyc;
        end
    endtask

    // Open a write cycle: data out, WE low for the pulse width
    task begin_wr;
        input [7:0] wbyte;
        begin
            dq_out <= wbyte;
            dq_oe <= 1'b1;
            we_n <= 1'b0;
            wr_idx_r <= wr_idx_r + 8'd1;
            arm(`PMFCP_TWEP_CYC);
            state_r <= S_WLOW;
        end
    endtask

    // Open a read cycle with the given access time
    task begin_rd;
        input [31:0] acc;
        begin
            oe_n <= 1'b0;
            arm(acc);
            state_r <= S_RACC;
        end
    endtask

    // Close the operation and hand the result back
    task finish;
        input [7:0] res;
        input tout;
        begin
            rsp_valid <= 1'b1;
            rsp_data <= res;
            rsp_timeout <= tout;
            ce_n <= 1'b1;
            fwe <= 1'b0;
            busy <= 1'b0;
            cmd_ready <= 1'b1;
            polling_r <= 1'b0;
            state_r <= S_IDLE;
        end
    endtask

    // Sequencer for command, page, poll and read cycles
    always @(posedge sys_clk) begin
        if (rst) begin
            state_r <= S_INIT;
            op_r <= `PMFCP_OP_READ;
            wr_idx_r <= 8'd0;
            rdata_r <= 8'h00;
            polling_r <= 1'b0;
            poll_cnt_r <= 32'h0;
            tmr_load_r <= 1'b1;
            tmr_val_r <= TINIT_CYC;
            cmd_ready <= 1'b0;
            pg_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_timeout <= 1'b0;
            busy <= 1'b1;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            fwe <= 1'b0;
            addr <= {AW{1'b0}};
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
        end else begin
            tmr_load_r <= 1'b0;
            rsp_valid <= 1'b0;
            case (state_r)
                S_INIT: begin
                    // Hold off until oscillator and mode setup have passed
                    if (tmr_done) begin
                        busy <= 1'b0;
                        cmd_ready <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    // Accept one operation; refused while any is running
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        busy <= 1'b1;
                        op_r <= cmd_op;
                        addr <= cmd_addr;
                        ce_n <= 1'b0;
                        fwe <= (cmd_op == `PMFCP_OP_PROG) || (cmd_op == `PMFCP_OP_ERASE);
                        poll_cnt_r <= 32'h0;
                        wr_idx_r <= 8'd0;
                        dq_out <= pmfcp_cmd_byte(cmd_op);
                        dq_oe <= 1'b1;
                        we_n <= 1'b0;
                        arm(`PMFCP_TWEP_CYC);
                        state_r <= S_WLOW;
                        wr_idx_r <= 8'd1;
                    end
                end
                S_WLOW: begin
                    // WE rises; data stays for the hold time
                    if (tmr_done) begin
                        we_n <= 1'b1;
                        arm(`PMFCP_TDH_CYC);
                        state_r <= S_WHOLD;
                    end
                end
                S_WHOLD: begin
                    if (tmr_done) begin
                        dq_oe <= 1'b0;
                        arm(TNXT_CYC);
                        state_r <= S_WGAP;
                    end
                end
                S_WGAP: begin
                    // Command cycle time passed; pick the next step
                    if (tmr_done) begin
                        case (op_r)
                            `PMFCP_OP_READ: begin
                                begin_rd(TACC_CYC);
                            end
                            `PMFCP_OP_PROG: begin
                                if (wr_idx_r == `PMFCP_PROG_WRITES) begin
                                    arm(TSTS_CYC);
                                    polling_r <= 1'b1;
                                    state_r <= S_PWAIT;
                                end else begin
                                    pg_ready <= 1'b1;
                                    state_r <= S_WNEED;
                                end
                            end
                            `PMFCP_OP_ERASE: begin
                                if (wr_idx_r == `PMFCP_TWO_WRITES) begin
                                    arm(TSTS_CYC);
                                    polling_r <= 1'b1;
                                    state_r <= S_PWAIT;
                                end else begin
                                    begin_wr(`PMFCP_CMD_ERASE);
                                end
                            end
                            default: begin
                                if (wr_idx_r == `PMFCP_TWO_WRITES) begin
                                    begin_rd(`PMFCP_TOE_CYC);
                                end else begin
                                    begin_wr(`PMFCP_CMD_STATUS);
                                end
                            end
                        endcase
                    end
                end
                S_WNEED: begin
                    // Page byte from the user; address stays at the page base
                    if (pg_valid && pg_ready) begin
                        pg_ready <= 1'b0;
                        begin_wr(pg_data);
                    end
                end
                S_PWAIT: begin
                    if (tmr_done) begin
                        begin_rd(`PMFCP_TOE_CYC);
                    end
                end
                S_RACC: begin
                    if (tmr_done) begin
                        rdata_r <= dq_in;
                        oe_n <= 1'b1;
                        arm(`PMFCP_TDF_CYC);
                        state_r <= S_RDF;
                    end
                end
                S_RDF: begin
                    if (tmr_done) begin
                        if (!polling_r) begin
                            finish(rdata_r, 1'b0);
                        end else if (rdata_r[`PMFCP_POLL_BIT]) begin
                            // Done: confirm with a status read, power kept on
                            polling_r <= 1'b0;
                            fwe <= 1'b0;
                            op_r <= `PMFCP_OP_STATUS;
                            wr_idx_r <= 8'd0;
                            dq_out <= `PMFCP_CMD_STATUS;
                            dq_oe <= 1'b1;
                            we_n <= 1'b0;
                            wr_idx_r <= 8'd1;
                            arm(`PMFCP_TWEP_CYC);
                            state_r <= S_WLOW;
                        end else if (poll_cnt_r == POLL_LIMIT) begin
                            finish(rdata_r, 1'b1);
                        end else begin
                            poll_cnt_r <= poll_cnt_r + 32'd1;
                            arm(TNXT_CYC);
                            state_r <= S_PWAIT;
                        end
                    end
                end
                default: begin
                    finish(8'h00, 1'b1);
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: rtl/pmfcp_defs.vh
// Constants for the flash command port controller: command bytes, ops and timing
`ifndef PMFCP_DEFS_VH
`define PMFCP_DEFS_VH

// System clock period
`define PMFCP_CLK_NS 4

// Command bytes written in the first (and second) command cycle
`define PMFCP_CMD_READ 8'h00
`define PMFCP_CMD_PROG 8'h40
`define PMFCP_CMD_ERASE 8'h20
`define PMFCP_CMD_STATUS 8'h71
// Filler for page bytes that must stay unchanged
`define PMFCP_FILL_BYTE 8'hff

// User operation codes
`define PMFCP_OP_READ 2'h0
`define PMFCP_OP_PROG 2'h1
`define PMFCP_OP_ERASE 2'h2
`define PMFCP_OP_STATUS 2'h3

// Page geometry and write cycle counts
`define PMFCP_PAGE_BYTES 128
`define PMFCP_PROG_WRITES 8'd129
`define PMFCP_TWO_WRITES 8'd2
// Bit of the data bus polled for completion
`define PMFCP_POLL_BIT 6

// Pin timing figures in their own units
`define PMFCP_TWEP_NS 70
`define PMFCP_TDH_NS 50
`define PMFCP_TOE_NS 150
`define PMFCP_TDF_NS 100
`define PMFCP_TNXT_US 20
`define PMFCP_TACC_US 20
`define PMFCP_TSTS_MS 1
`define PMFCP_TOSC_MS 20
`define PMFCP_TSETUP_MS 10
`define PMFCP_TERASE_MAX_MS 40000

// Least times rounded up to whole clock cycles
`define PMFCP_TWEP_CYC ((`PMFCP_TWEP_NS + `PMFCP_CLK_NS - 1) / `PMFCP_CLK_NS)
`define PMFCP_TDH_CYC ((`PMFCP_TDH_NS + `PMFCP_CLK_NS - 1) / `PMFCP_CLK_NS)
`define PMFCP_TOE_CYC ((`PMFCP_TOE_NS + `PMFCP_CLK_NS - 1) / `PMFCP_CLK_NS)
`define PMFCP_TDF_CYC ((`PMFCP_TDF_NS + `PMFCP_CLK_NS - 1) / `PMFCP_CLK_NS)
`define PMFCP_TNXT_CYC ((`PMFCP_TNXT_US * 1000 + `PMFCP_CLK_NS - 1) / `PMFCP_CLK_NS)
`define PMFCP_TACC_CYC ((`PMFCP_TACC_US * 1000 + `PMFCP_CLK_NS - 1) / `PMFCP_CLK_NS)
`define PMFCP_TSTS_CYC ((`PMFCP_TSTS_MS * 1000000 + `PMFCP_CLK_NS - 1) / `PMFCP_CLK_NS)
`define PMFCP_TINIT_CYC (((`PMFCP_TOSC_MS + `PMFCP_TSETUP_MS) * 1000000 + `PMFCP_CLK_NS - 1) / `PMFCP_CLK_NS)
// Poll attempts covering the longest erase, one poll per command gap
`define PMFCP_POLL_LIMIT (`PMFCP_TERASE_MAX_MS * 1000 / `PMFCP_TNXT_US)

`endif

// file: rtl/pmfcp_timer.v
// Reloadable down-counter timing the pin phases
`timescale 1ns/1ns
`default_nettype none
module pmfcp_timer #(
    parameter W = 32
) (
    input wire sys_clk,
    input wire rst,
    input wire load,
    input wire [W-1:0] load_val,
    output wire expired
);
    reg [W-1:0] cnt_r;

    // Load on request, otherwise count down to zero and stop
    always @(posedge sys_clk) begin
        if (rst) begin
            cnt_r <= {W{1'b0}};
        end else if (load) begin
            cnt_r <= load_val;
        end else if (cnt_r != {W{1'b0}}) begin
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    // Not expired in the load cycle, so a stale zero is never seen
    assign expired = (cnt_r == {W{1'b0}}) && !load;
endmodule
`default_nettype wire

// file: tb/pmfcp_ctrl_checker.sv
// Pin protocol assertions for the flash command port controller
`timescale 1ns/1ns
`default_nettype none
module pmfcp_ctrl_checker #(
    parameter TNXT_CYC = 20,
    parameter TSTS_CYC = 50,
    parameter TINIT_CYC = 30
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic busy,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic fwe,
    input wire logic [17:0] addr,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    input wire logic [7:0] dq_in
);
    logic [1:0] op_r;
    logic [7:0] wcnt_r, cmdb;
    logic [15:0] up_r, fall_r, rise_r;
    logic seen_r;
    assign cmdb = op_r == 2'h0 ? 8'h00 : op_r == 2'h1 ? 8'h40 : op_r == 2'h2 ? 8'h20 : 8'h71;
    // Operation, write count, poll result and cycle counters
    always @(posedge sys_clk) begin
        if (rst) begin
            op_r <= 2'h0;
            wcnt_r <= 8'h00;
            seen_r <= 1'b0;
            up_r <= 16'h0000;
            fall_r <= 16'hffff;
            rise_r <= 16'hffff;
        end else begin
            op_r <= (cmd_valid && cmd_ready) ? cmd_op : op_r;
            wcnt_r <= (cmd_valid && cmd_ready) ? 8'h00 : wcnt_r + {7'h00, $fell(we_n)};
            seen_r <= !(cmd_valid && cmd_ready) && (seen_r || (fwe && !oe_n && dq_in[6]));
            up_r <= up_r + {15'h0000, up_r != 16'hffff};
            fall_r <= $fell(we_n) ? 16'h0001 : fall_r + {15'h0000, fall_r != 16'hffff};
            rise_r <= $rose(we_n) ? 16'h0001 : rise_r + {15'h0000, rise_r != 16'hffff};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_we_low;
        (!we_n)[*8] ##1 (!we_n)[*8] ##1 (!we_n)[*2];
    endsequence
    sequence s_dq_hold;
        (dq_oe && $stable(dq_out))[*8] ##1 (dq_oe && $stable(dq_out))[*5];
    endsequence
    property p_cmd_byte;
        $fell(we_n) && (wcnt_r == 8'h00 || (wcnt_r == 8'h01 && op_r[1])) |-> dq_out == cmdb;
    endproperty
    property p_we_width;
        $fell(we_n) |-> s_we_low;
    endproperty
    property p_dq_hold;
        $rose(we_n) |-> s_dq_hold;
    endproperty
    property p_strobes;
        !we_n || !oe_n |-> !ce_n && (we_n != oe_n) && (dq_oe == !we_n);
    endproperty
    property p_write_gap;
        $fell(we_n) |-> fall_r >= TNXT_CYC;
    endproperty
    property p_prog_count;
        $fell(fwe) |-> wcnt_r == (op_r == 2'h1 ? 8'h81 : 8'h02);
    endproperty
    property p_no_write_busy;
        fwe && wcnt_r == (op_r == 2'h1 ? 8'h81 : 8'h02) |-> !$fell(we_n);
    endproperty
    property p_poll_start;
        fwe && $fell(oe_n) |-> rise_r >= TSTS_CYC;
    endproperty
    property p_status_after;
        $fell(fwe) && seen_r |-> ##[1:200] (!we_n && dq_out == 8'h71);
    endproperty
    property p_init;
        up_r < TINIT_CYC |-> ce_n && !cmd_ready;
    endproperty
    property p_rsp;
        rsp_valid |-> cmd_ready && !busy && we_n && oe_n;
    endproperty
    property p_addr_hold;
        !ce_n && !$past(ce_n) |-> $stable(addr);
    endproperty
    a_cmd_byte: assert property (p_cmd_byte) else $error("wrong command byte");
    a_we_width: assert property (p_we_width) else $error("write pulse too short");
    a_dq_hold: assert property (p_dq_hold) else $error("write data not held");
    a_strobes: assert property (p_strobes) else $error("bad strobe combination");
    a_write_gap: assert property (p_write_gap) else $error("write cycles too close");
    a_prog_count: assert property (p_prog_count) else $error("wrong write count");
    a_no_write_busy: assert property (p_no_write_busy) else $error("write while busy");
    a_poll_start: assert property (p_poll_start) else $error("poll too early");
    a_status_after: assert property (p_status_after) else $error("no status read");
    a_init: assert property (p_init) else $error("activity during setup");
    a_rsp: assert property (p_rsp) else $error("response while active");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved during operation");
endmodule
bind pmfcp_ctrl pmfcp_ctrl_checker #(.TNXT_CYC(TNXT_CYC), .TSTS_CYC(TSTS_CYC), .TINIT_CYC(TINIT_CYC)) chk (.*);
`default_nettype wire

// file: tb/pmfcp_ctrl_tb.sv
// Self-checking bench for the flash command port controller
`timescale 1ns/1ns
`default_nettype none
module pmfcp_ctrl_tb;
    typedef struct packed {logic [1:0] op; logic [17:0] a; logic [1:0] s; logic [7:0] e;} pmfcp_row_t;
    logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, pg_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0, speed = 2'h0;
    logic [17:0] cmd_addr = 18'h00000, addr;
    logic [7:0] pg_data = 8'h00, rsp_data, dq_out, dq_in;
    logic cmd_ready, pg_ready, rsp_valid, rsp_timeout, busy, ce_n, oe_n, we_n, fwe, dq_oe, viol;
    int bad_count = 0, check_count = 0, waited;
    pmfcp_row_t rows [9] = '{
        '{2'h0, 18'h00080, 2'h0, 8'hff},
        '{2'h3, 18'h00000, 2'h0, 8'h00},
        '{2'h1, 18'h00080, 2'h0, 8'h00},
        '{2'h0, 18'h00080, 2'h0, 8'ha5},
        '{2'h0, 18'h000fb, 2'h0, 8'hde},
        '{2'h0, 18'h000fc, 2'h0, 8'hff},
        '{2'h1, 18'h20000, 2'h1, 8'h81},
        '{2'h2, 18'h00000, 2'h1, 8'h00},
        '{2'h0, 18'h00080, 2'h0, 8'hff}
    };
    pmfcp_ctrl #(.TNXT_CYC(20), .TACC_CYC(20), .TSTS_CYC(50), .TINIT_CYC(30), .POLL_LIMIT(8)) dut (.*);
    pmfcp_flash_model dev (.*);
    always #2 sys_clk = ~sys_clk;
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask
    // Bounded wait: 0 idle, 1 page byte wanted, 2 response
    task automatic wait_on(input int w);
        waited = 0;
        do begin
            @(posedge sys_clk);
            waited++;
        end while ((w == 0 ? cmd_ready : w == 1 ? pg_ready : rsp_valid) !== 1'b1 && waited < 40000);
        if (waited >= 40000) begin
            bad_count++;
            $display("FAIL wait %0d expected 1 seen 0", w);
            finish_test();
        end
    endtask
    task automatic start(input logic [1:0] op, input logic [17:0] a, input logic [1:0] s);
        cmd_op <= op;
        cmd_addr <= a;
        speed <= s;
        cmd_valid <= 1'b1;
        wait_on(0);
        cmd_valid <= 1'b0;
    endtask
    // Page tail padded so those bytes stay erased
    function automatic logic [7:0] pg_byte(input int n);
        return n < 124 ? n[7:0] ^ 8'ha5 : 8'hff;
    endfunction
    // One operation with page feed, occasional user stall, and result check
    task automatic do_op(input pmfcp_row_t r);
        start(r.op, r.a, r.s);
        if (r.op == 2'h1) begin
            for (int n = 0; n < 128; n++) begin
                if (n % 40 == 7) begin
                    pg_valid <= 1'b0;
                    repeat (60) @(posedge sys_clk);
                end
                pg_valid <= 1'b1;
                pg_data <= pg_byte(n);
                wait_on(1);
            end
            pg_valid <= 1'b0;
        end
        wait_on(2);
        chk8("rsp_data", r.e, rsp_data);
        chk1("rsp_timeout", r.s == 2'h2, rsp_timeout);
    endtask
    // Reset, aborted read, table of operations, then a device that never ends
    initial begin
        repeat (3) @(posedge sys_clk);
        chk1("ce_n in reset", 1'b1, ce_n);
        chk1("ready in reset", 1'b0, cmd_ready);
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        wait_on(0);
        chk1("setup wait", 1'b1, waited >= 30);
        start(2'h0, 18'h00040, 2'h0);
        repeat (45) @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        chk1("we_n after reset", 1'b1, we_n);
        chk1("dq_oe after reset", 1'b0, dq_oe);
        wait_on(0);
        foreach (rows[i]) do_op(rows[i]);
        do_op('{2'h1, 18'h00100, 2'h2, 8'h00});
        chk1("device protocol", 1'b0, viol);
        finish_test();
    end
endmodule
`default_nettype wire

// file: tb/pmfcp_flash_model.sv
// Behavioural flash device on the far side of the command port
`timescale 1ns/1ns
`default_nettype none
module pmfcp_flash_model #(
    parameter int SETUP_NS = 100,
    parameter int STS_NS = 200
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic fwe,
    input wire logic [17:0] addr,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    input wire logic [1:0] speed,
    output logic [7:0] dq_in,
    output logic viol
);
    logic [7:0] mem [int];
    bit used_pg [int];
    logic [7:0] pg [128];
    logic [7:0] st = 8'h00, cmd = 8'h00, last = 8'h00, rd;
    logic [17:0] base;
    logic done = 1'b1;
    int cnt = 0, mode = 0; // 0 read, 1 page, 2 poll, 3 status, 4 erase, 5 status cmd
    time t_end = 0;
    initial viol = 1'b0;
    // Internal program or erase, finished after a delay set by speed
    task automatic run_op(input bit prog);
        done = 1'b0;
        mode = 2;
        t_end = $time;
        st = prog ? {base[17], 6'h00, base[17]} : 8'h00;
        fork begin
            #(speed == 2'h0 ? 100 : speed == 2'h1 ? 1000 : 10000000);
            if (prog) begin
                if (used_pg.exists(base)) viol = 1'b1;
                used_pg[base] = 1'b1;
                foreach (pg[i]) mem[base + i] = pg[i];
            end else begin
                mem.delete();
                used_pg.delete();
            end
            done = 1'b1;
        end join_none
    endtask
    // Write cycles latched at the rising write strobe
    always @(posedge we_n) begin
        if (!ce_n && $time >= SETUP_NS) begin
            if (!dq_oe || !done) viol = 1'b1;
            else if (mode == 1) begin
                if (cnt == 0) base = addr;
                else if (addr !== base) viol = 1'b1;
                pg[cnt] = dq_out;
                cnt++;
                if (cnt == 128) run_op(1'b1);
            end else if (mode >= 4) begin
                if (dq_out !== cmd) st[6] = 1'b1;
                if (dq_out !== cmd) mode = 0;
                else if (mode == 4) run_op(1'b0);
                else mode = 3;
            end else begin
                cmd = dq_out;
                case (dq_out)
                    8'h00: mode = 0;
                    8'h40: begin
                        mode = 1;
                        cnt = 0;
                        viol |= !fwe;
                    end
                    8'h20: begin
                        mode = 4;
                        viol |= !fwe;
                    end
                    8'h71: mode = 5;
                    default: st[6] = 1'b1;
                endcase
            end
        end
    end
    // Read data by mode; a released bus shows its last value inverted
    always @* begin
        case (mode)
            2: rd = {1'b0, done, 6'h00};
            3: rd = st;
            default: rd = mem.exists(addr) ? mem[addr] : 8'hff;
        endcase
        dq_in = (!ce_n && !oe_n && we_n && !dq_oe) ? rd : ~last;
    end
    always @(posedge oe_n) last <= rd;
    // Polling too soon after the last write
    always @(negedge oe_n) if (!ce_n && mode == 2 && $time - t_end < STS_NS) viol = 1'b1;
endmodule
`default_nettype wire
